// ==== deg_gpio_io.sv ====
/*
  I/O logic of one general-purpose pin with single and dual-edge registers,
  resync option, output inversion and an unregistered bypass input.
  Assumes rx_reg_clock and tx_reg_clock are much slower than pclk; their
  edges are found after a two-stage synchroniser. APB slave, zero wait.
*/
// Design decisions made here: the placing of the registers and the APB register port.
// Contract
// RULE1: single rate uses only first input bit
// RULE2: dual input: rise sample bit0, fall bit1
// RULE3: dual output: bit0 at rise, bit1 fall
// RULE4: output enable optionally registered
// RULE5: output clock drives data and enable registers
// RULE6: input registers use separate input clock
// RULE7: unregistered bypass input when no register
// RULE8: dual mode exchanges two-bit word
// RULE9: normal dual mode passes bits unaligned
// RULE10: resync aligns both bits to rising edge
// RULE11: resync delays fall sample half cycle
// RULE12: single-ended pair: no dual, no pulldown
// RULE13: edge selectable, paths registered independently
// RULE14: optional output register inversion
// RULE15: registers hold between edges; bypass combinational
`timescale 1ns/1ps
`default_nettype none
module deg_gpio_io (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic [deg_pkg::DEG_AW-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [deg_pkg::DEG_DW-1:0]  pwdata,
  output logic                             pready,
  output logic [deg_pkg::DEG_DW-1:0]       prdata,
  output logic                             pslverr,
  // core side
  input  wire logic                        rx_reg_clock,
  input  wire logic                        tx_reg_clock,
  output logic                             rx_bit_rise,
  output logic                             rx_bit_fall,
  output logic                             bypass_input,
  input  wire logic                        tx_bit_rise,
  input  wire logic                        tx_bit_fall,
  input  wire logic                        tx_oe,
  // pad
  input  wire logic                        pad_i,
  output logic                             pad_o,
  output logic                             pad_oe,
  output logic                             pad_pulldown
);
  import deg_pkg::*;

  localparam int unsigned CNTW = $clog2(DEG_FIFO_D) + 1;

  logic [DEG_CW-1:0]     ctrl_r;
  logic                  ovf_r;
  logic                  rx_s1_r, rx_s2_r, rx_s3_r;
  logic                  tx_s1_r, tx_s2_r, tx_s3_r;
  logic                  pad_s1_r, pad_s2_r;
  logic                  rx_rise, rx_fall, tx_rise, tx_fall, rx_ev, tx_ev;
  logic                  in_reg, in_dual, in_resync;
  logic                  out_reg, out_dual, out_resync, out_inv, oe_reg;
  logic                  rx0_r, rx1_r, fall_hold_r;
  logic                  tx0_r, tx1_r, oe_q_r;
  logic                  push_r;
  logic                  push_nxt;
  logic                  f_ready, f_valid, f_pop;
  logic [DEG_FIFO_W-1:0] f_data;
  logic [CNTW-1:0]       f_count;
  logic                  acc, ctrl_wr, stat_wr, data_rd, mapped;

  // configuration decode; a single-ended pair cannot run dual-edge
  assign in_reg     = ctrl_r[DEG_C_IN_REG];
  assign in_dual    = in_reg & ctrl_r[DEG_C_IN_DUAL] & ~ctrl_r[DEG_C_SE_PAIR];       // RULE12
  assign in_resync  = ctrl_r[DEG_C_IN_RESYNC];
  assign out_reg    = ctrl_r[DEG_C_OUT_REG];
  assign out_dual   = out_reg & ctrl_r[DEG_C_OUT_DUAL] & ~ctrl_r[DEG_C_SE_PAIR];     // RULE12
  assign out_resync = ctrl_r[DEG_C_OUT_RESYNC];
  assign out_inv    = ctrl_r[DEG_C_OUT_INV];
  assign oe_reg     = ctrl_r[DEG_C_OE_REG];
  assign pad_pulldown = ctrl_r[DEG_C_PULLDN] & ~ctrl_r[DEG_C_SE_PAIR];             // RULE12

  // apb decode
  assign acc     = psel & penable;
  assign mapped  = (paddr == DEG_OFS_CTRL) | (paddr == DEG_OFS_STATUS) | (paddr == DEG_OFS_DATA);
  assign ctrl_wr = acc & pwrite & (paddr == DEG_OFS_CTRL);
  assign stat_wr = acc & pwrite & (paddr == DEG_OFS_STATUS);
  assign data_rd = acc & ~pwrite & (paddr == DEG_OFS_DATA);
  assign f_pop   = data_rd;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    prdata = '0;
    if (acc && !pwrite) begin
      case (paddr)
        DEG_OFS_CTRL: begin
          prdata[DEG_CW-1:0] = ctrl_r;
        end
        DEG_OFS_STATUS: begin
          prdata[DEG_S_RX_RISE] = rx_bit_rise;
          prdata[DEG_S_RX_FALL] = rx_bit_fall;
          prdata[DEG_S_PAD]     = pad_s2_r;
          prdata[DEG_S_OVF]     = ovf_r;
          prdata[DEG_S_EMPTY]   = ~f_valid;
          prdata[DEG_S_CNT_LO +: CNTW] = f_count;
        end
        DEG_OFS_DATA: begin
          prdata[DEG_FIFO_W-1:0] = f_valid ? f_data : '0;
        end
        default: begin
          prdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= DEG_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= pwdata[DEG_CW-1:0];
    end
  end

  // overflow: a lost word in the clearing cycle still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
    end else if (push_r && !f_ready) begin
      ovf_r <= 1'b1;
    end else if (stat_wr && pwdata[DEG_S_OVF]) begin
      ovf_r <= 1'b0;
    end
  end

  // synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_s1_r, rx_s2_r, rx_s3_r}    <= 3'h0;
      {tx_s1_r, tx_s2_r, tx_s3_r}    <= 3'h0;
      {pad_s1_r, pad_s2_r}           <= 2'h0;
    end else begin
      {rx_s1_r, rx_s2_r, rx_s3_r}    <= {rx_reg_clock, rx_s1_r, rx_s2_r};
      {tx_s1_r, tx_s2_r, tx_s3_r}    <= {tx_reg_clock, tx_s1_r, tx_s2_r};
      {pad_s1_r, pad_s2_r}           <= {pad_i, pad_s1_r};
    end
  end

  assign rx_rise = rx_s2_r & ~rx_s3_r;
  assign rx_fall = ~rx_s2_r & rx_s3_r;
  assign tx_rise = tx_s2_r & ~tx_s3_r;
  assign tx_fall = ~tx_s2_r & tx_s3_r;
  assign rx_ev   = ctrl_r[DEG_C_IN_NEG] ? rx_fall : rx_rise;                        // RULE13
  assign tx_ev   = ctrl_r[DEG_C_OUT_NEG] ? tx_fall : tx_rise;                       // RULE13

  // input capture, timed only by the input clock
  always_ff @(posedge pclk or negedge presetn) begin                                // RULE6
    if (!presetn) begin
      rx0_r       <= 1'b0;
      rx1_r       <= 1'b0;
      fall_hold_r <= 1'b0;
    end else if (!in_dual) begin
      rx1_r <= 1'b0;                                                               // RULE1
      if (in_reg && rx_ev) begin
        rx0_r <= pad_s2_r;                                                         // RULE15
      end
    end else if (in_resync) begin
      if (rx_fall) begin
        fall_hold_r <= pad_s2_r;
      end
      if (rx_rise) begin
        rx0_r <= pad_s2_r;                                                         // RULE10
        rx1_r <= fall_hold_r;                                                      // RULE11
      end
    end else begin
      if (rx_rise) begin
        rx0_r <= pad_s2_r;                                                         // RULE2
      end
      if (rx_fall) begin
        rx1_r <= pad_s2_r;                                                         // RULE9
      end
    end
  end

  // unregistered path is the synchronised pad level, no edge involved
  assign rx_bit_rise  = in_reg ? rx0_r : pad_s2_r;                                 // RULE15
  assign rx_bit_fall  = rx1_r;                                                     // RULE1
  assign bypass_input = in_reg ? 1'b0 : pad_s2_r;                                  // RULE7

  // push a word once it is complete
  always_comb begin
    push_nxt = 1'b0;
    if (in_dual) begin
      push_nxt = in_resync ? rx_rise : rx_fall;                                    // RULE8
    end else if (in_reg) begin
      push_nxt = rx_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_r <= 1'b0;
    end else begin
      push_r <= push_nxt;
    end
  end

  // word lost when full; software drains through the data register
  deg_fifo #(
    .WIDTH (DEG_FIFO_W),
    .DEPTH (DEG_FIFO_D)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (push_r),
    .in_ready  (f_ready),
    .in_data   ({rx1_r, rx0_r}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data),
    .count     (f_count)
  );

  // output data and enable registers, timed only by the output clock
  always_ff @(posedge pclk or negedge presetn) begin                                // RULE5
    if (!presetn) begin
      tx0_r <= 1'b0;
      tx1_r <= 1'b0;
    end else if (!out_dual) begin
      if (tx_ev) begin
        tx0_r <= tx_bit_rise;                                                      // RULE15
      end
    end else if (out_resync) begin
      if (tx_rise) begin
        tx0_r <= tx_bit_rise;                                                      // RULE10
        tx1_r <= tx_bit_fall;
      end
    end else begin
      if (tx_rise) begin
        tx0_r <= tx_bit_rise;                                                      // RULE9
      end
      if (tx_fall) begin
        tx1_r <= tx_bit_fall;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q_r <= 1'b0;
    end else if (tx_ev) begin
      oe_q_r <= tx_oe;                                                             // RULE5
    end
  end

  // high phase carries the rise bit, low phase the fall bit
  assign pad_o  = out_reg ? (out_inv ^ (out_dual ? (tx_s2_r ? tx0_r : tx1_r) : tx0_r))   // RULE3
                          : tx_bit_rise;                                                  // RULE14
  assign pad_oe = oe_reg ? oe_q_r : tx_oe;                                          // RULE4

  property p_single_fall_zero;
    @(posedge pclk) disable iff (!presetn) !in_dual |=> (rx_bit_fall == 1'b0);
  endproperty
  a_single_fall_zero: assert property (p_single_fall_zero) else $error("fall bit set in single rate"); // RULE1

  property p_dual_rise;
    @(posedge pclk) disable iff (!presetn)
      (in_dual && rx_rise && !ctrl_wr) |=> (rx0_r == $past(pad_s2_r));
  endproperty
  a_dual_rise: assert property (p_dual_rise) else $error("rise sample wrong"); // RULE2

  property p_dual_fall;
    @(posedge pclk) disable iff (!presetn)
      (in_dual && !in_resync && rx_fall) |=> (rx_bit_fall == $past(pad_s2_r));
  endproperty
  a_dual_fall: assert property (p_dual_fall) else $error("fall sample not passed"); // RULE9

  // witness of the last resync fall sample, kept apart from the capture logic
  logic fall_seen_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_seen_r <= 1'b0;
    end else if (in_dual && in_resync && rx_fall) begin
      fall_seen_r <= pad_s2_r;
    end
  end

  property p_resync_delay;
    @(posedge pclk) disable iff (!presetn)
      (in_dual && in_resync && rx_rise) |=> (rx_bit_fall == $past(fall_seen_r));
  endproperty
  a_resync_delay: assert property (p_resync_delay) else $error("resync fall bit wrong"); // RULE11

  property p_resync_tx;
    @(posedge pclk) disable iff (!presetn)
      (out_dual && out_resync && tx_rise) |=> (tx1_r == $past(tx_bit_fall));
  endproperty
  a_resync_tx: assert property (p_resync_tx) else $error("tx resync missed"); // RULE10

  property p_dual_out;
    @(posedge pclk) disable iff (!presetn)
      (out_dual && !out_inv && tx_rise && !ctrl_wr) |=> (!tx_s2_r || pad_o == $past(tx_bit_rise));
  endproperty
  a_dual_out: assert property (p_dual_out) else $error("rise bit not on pad"); // RULE3

  property p_oe_reg;
    @(posedge pclk) disable iff (!presetn)
      (oe_reg && tx_ev && !ctrl_wr) |=> (pad_oe == $past(tx_oe));
  endproperty
  a_oe_reg: assert property (p_oe_reg) else $error("registered enable wrong"); // RULE4

  property p_invert;
    @(posedge pclk) disable iff (!presetn)
      (out_reg && !out_dual && out_inv && tx_ev && !ctrl_wr) |=> (pad_o == !$past(tx_bit_rise));
  endproperty
  a_invert: assert property (p_invert) else $error("inversion missing"); // RULE14

  property p_in_hold;
    @(posedge pclk) disable iff (!presetn)
      (in_reg && !in_dual && !rx_ev) |=> $stable(rx0_r);
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("input register moved off edge"); // RULE15

  property p_in_clock_only;
    @(posedge pclk) disable iff (!presetn)
      (in_dual && !rx_rise && !rx_fall) |=> ($stable(rx0_r) && $stable(rx1_r));
  endproperty
  a_in_clock_only: assert property (p_in_clock_only) else $error("capture without input edge"); // RULE6

  property p_bypass;
    @(posedge pclk) disable iff (!presetn) (!in_reg && !ctrl_wr) |=> (bypass_input == $past(pad_s1_r));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass differs from pad"); // RULE7

  property p_se_pair;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r[DEG_C_SE_PAIR] |-> (!in_dual && !out_dual && !pad_pulldown);
  endproperty
  a_se_pair: assert property (p_se_pair) else $error("dual or pulldown on pair pin"); // RULE12

  property p_word_push;
    @(posedge pclk) disable iff (!presetn)
      (in_dual && !in_resync && rx_fall && !ctrl_wr) |=> push_r;
  endproperty
  a_word_push: assert property (p_word_push) else $error("dual word not pushed"); // RULE8

  c_resync_in: cover property (@(posedge pclk) disable iff (!presetn) in_dual && in_resync && push_r);
  c_dual_out:  cover property (@(posedge pclk) disable iff (!presetn) out_dual && tx_fall);
  c_overflow:  cover property (@(posedge pclk) disable iff (!presetn) push_r && !f_ready);
endmodule
`default_nettype wire

// ==== deg_pkg.sv ====
/*
  Package for the dual-edge GPIO I/O logic: register offsets, control and
  status field positions, reset values and capture buffer sizes.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit offset bus.
*/
package deg_pkg;
  localparam int unsigned DEG_AW           = 8;
  localparam int unsigned DEG_DW           = 32;
  localparam logic [7:0]  DEG_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  DEG_OFS_STATUS   = 8'h04;
  localparam logic [7:0]  DEG_OFS_DATA     = 8'h08;

  // control register fields
  localparam int unsigned DEG_CW           = 12;
  localparam int unsigned DEG_C_IN_REG     = 0;
  localparam int unsigned DEG_C_IN_NEG     = 1;
  localparam int unsigned DEG_C_IN_DUAL    = 2;
  localparam int unsigned DEG_C_IN_RESYNC  = 3;
  localparam int unsigned DEG_C_OUT_REG    = 4;
  localparam int unsigned DEG_C_OUT_NEG    = 5;
  localparam int unsigned DEG_C_OUT_DUAL   = 6;
  localparam int unsigned DEG_C_OUT_RESYNC = 7;
  localparam int unsigned DEG_C_OE_REG     = 8;
  localparam int unsigned DEG_C_OUT_INV    = 9;
  localparam int unsigned DEG_C_SE_PAIR    = 10;
  localparam int unsigned DEG_C_PULLDN     = 11;
  localparam logic [11:0] DEG_CTRL_RST     = 12'h000;

  // status register fields
  localparam int unsigned DEG_S_RX_RISE    = 0;
  localparam int unsigned DEG_S_RX_FALL    = 1;
  localparam int unsigned DEG_S_PAD        = 2;
  localparam int unsigned DEG_S_OVF        = 3;
  localparam int unsigned DEG_S_EMPTY      = 4;
  localparam int unsigned DEG_S_CNT_LO     = 5;

  // capture buffer
  localparam int unsigned DEG_FIFO_W       = 2;
  localparam int unsigned DEG_FIFO_D       = 16;
endpackage

// ==== deg_fifo.sv ====
/*
  Synchronous FIFO holding captured input words.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/1ps
`default_nettype none
module deg_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 16,
  localparam int unsigned AW   = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // fill level
  output logic [AW:0]           count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;

  assign count     = wp_r - rp_r;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rp_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== deg_pad_model.sv ====
/*
  Model of the device wired to the pin's pad: it drives the pad when told to,
  otherwise the pin's own driver, or its pull when released, decides the level.
  Assumes the bench steers ext_en and never lets both sides drive on purpose.
*/
`timescale 1ns/1ps
`default_nettype none
module deg_pad_model (
  // pin side
  input  wire logic pad_o,
  input  wire logic pad_oe,
  input  wire logic pad_pulldown,
  // far device
  input  wire logic ext_en,
  input  wire logic ext_val,
  // resolved pad level
  output logic      pad_i
);
  // no keeper: a released pad falls to its pull, weak pull-up by default
  always_comb begin
    if (pad_oe && ext_en)
      pad_i = 1'bx;
    else if (pad_oe)
      pad_i = pad_o;
    else if (ext_en)
      pad_i = ext_val;
    else
      pad_i = ~pad_pulldown;
  end
endmodule
`default_nettype wire

// ==== tb_dual_edge_gpio_io_logic.sv ====
/*
  Self-checking bench for the pin logic: registers over apb, capture modes,
  output modes, capture buffer and pulls.
  Assumes deg_pkg, deg_fifo, deg_gpio_io and deg_pad_model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dual_edge_gpio_io_logic;
  import deg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v, seed, mismatches, check_count;
  logic        rx_reg_clock, tx_reg_clock, rx_bit_rise, rx_bit_fall, bypass_input;
  logic        tx_bit_rise, tx_bit_fall, tx_oe, pad_i, pad_o, pad_oe, pad_pulldown;
  logic        ext_en, ext_val, err, a1, b1, a2, b2, r, f;
  logic [1:0]  q[$];
  logic [11:0] in_modes [6] = '{12'h000, 12'h001, 12'h003, 12'h005, 12'h00D, 12'h405};
  logic [11:0] tx_modes [9] = '{12'h000, 12'h010, 12'h030, 12'h050, 12'h0D0, 12'h250, 12'h450, 12'h110,
                                12'h210};
  int          k;

  deg_gpio_io dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_reg_clock(rx_reg_clock), .tx_reg_clock(tx_reg_clock), .rx_bit_rise(rx_bit_rise),
    .rx_bit_fall(rx_bit_fall), .bypass_input(bypass_input), .tx_bit_rise(tx_bit_rise),
    .tx_bit_fall(tx_bit_fall), .tx_oe(tx_oe), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
    .pad_pulldown(pad_pulldown));
  deg_pad_model pad_u (.pad_o(pad_o), .pad_oe(pad_oe), .pad_pulldown(pad_pulldown), .ext_en(ext_en),
    .ext_val(ext_val), .pad_i(pad_i));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[3];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // master waits for pready itself; the count and the bench timeout guard a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50)
      mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    cyc(16);
    presetn <= 1'b1;
    cyc(2);
  endtask

  // slow core clock: pad settles through its synchroniser before each edge
  task automatic cap(input logic a, input logic b);
    ext_val <= a;
    cyc(4);
    rx_reg_clock <= 1'b1;
    cyc(8);
    ext_val <= b;
    cyc(4);
    rx_reg_clock <= 1'b0;
    cyc(8);
  endtask

  // returns {bypass, second bit, first bit}; bp is the earlier fall sample
  function automatic logic [2:0] exp_in(input logic [11:0] m, input logic a, input logic bp, input logic b);
    case (m)
      12'h000: return {b, 1'b0, b};
      12'h003: return {2'b00, b};
      12'h005: return {1'b0, b, a};
      12'h00D: return {1'b0, bp, a};
      default: return {2'b00, a};
    endcase
  endfunction

  // returns {pad_oe, pad_o}; ph 0 after the rise, 1 after the fall
  function automatic logic [1:0] exp_tx(input logic [11:0] m, input logic r, input logic f, input logic ph);
    logic d;
    logic o;
    d = m[6] && !m[10];
    if (!m[4])
      o = ~r;
    else if (!ph)
      o = r ^ m[9];
    else if (!d)
      o = (m[5] ? ~r : r) ^ m[9];
    else
      o = (m[7] ? f : ~f) ^ m[9];
    return {m[8], o};
  endfunction

  // inputs flip after the rising edge so held register values are told apart
  task automatic tx_run(input logic [11:0] m);
    r = rnd();
    f = rnd();
    tx_bit_rise <= r;
    tx_bit_fall <= f;
    tx_oe <= 1'b1;
    cyc(4);
    tx_reg_clock <= 1'b1;
    cyc(8);
    tx_bit_rise <= ~r;
    tx_bit_fall <= ~f;
    tx_oe <= 1'b0;
    cyc(1);
    if (m != 12'h030)
      chk({pad_oe, pad_o}, exp_tx(m, r, f, 1'b0));
    tx_reg_clock <= 1'b0;
    cyc(8);
    chk(pad_o, exp_tx(m, r, f, 1'b1) & 2'b01);
  endtask

  initial begin
    #100000;
    mismatches++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, rx_reg_clock, tx_reg_clock, tx_bit_rise, tx_bit_fall, tx_oe} = '0;
    paddr = '0;
    pwdata = '0;
    ext_en = 1'b1;
    ext_val = 1'b0;
    presetn = 1'b0;
    seed = 32'd34;
    mismatches = '0;
    check_count = '0;
    do_reset();
    apb(1'b0, DEG_OFS_CTRL, '0);
    chk(rd, {20'h0, DEG_CTRL_RST});
    v = {20'h0, seed[11:0] & 12'h3F0};
    apb(1'b1, DEG_OFS_CTRL, v);
    apb(1'b1, 8'h0C, 32'hFFF);
    chk(err, 1'b1);
    apb(1'b0, DEG_OFS_CTRL, '0);
    chk(rd & 32'hFFF, v);
    apb(1'b0, 8'h10, '0);
    chk({err, rd[30:0]}, {1'b1, 31'h0});
    // buffer: one word past full is dropped
    apb(1'b1, DEG_OFS_CTRL, 32'h001);
    for (k = 0; k < 17; k++) begin
      a1 = rnd();
      b1 = rnd();
      cap(a1, b1);
      if (k < 16)
        q.push_back({1'b0, a1});
    end
    apb(1'b0, DEG_OFS_STATUS, '0);
    chk(rd[9:0], {5'd16, 1'b0, 1'b1, b1, 1'b0, a1});
    while (q.size() > 0) begin
      apb(1'b0, DEG_OFS_DATA, '0);
      chk(rd[1:0], q.pop_front());
    end
    apb(1'b1, DEG_OFS_STATUS, 32'h8);
    apb(1'b0, DEG_OFS_STATUS, '0);
    chk(rd[9:3], 7'b0000010);
    apb(1'b0, DEG_OFS_DATA, '0);
    chk(rd, 32'h0);
    do_reset();
    apb(1'b0, DEG_OFS_CTRL, '0);
    chk(rd, {20'h0, DEG_CTRL_RST});
    for (k = 0; k < 6; k++) begin
      apb(1'b1, DEG_OFS_CTRL, {20'h0, in_modes[k]});
      a1 = rnd();
      b1 = rnd();
      a2 = rnd();
      b2 = ~b1;
      cap(a1, b1);
      cap(a2, b2);
      chk({bypass_input, rx_bit_fall, rx_bit_rise}, exp_in(in_modes[k], a2, b1, b2));
    end
    ext_en <= 1'b0;
    for (k = 0; k < 9; k++) begin
      apb(1'b1, DEG_OFS_CTRL, {20'h0, tx_modes[k]});
      tx_run(tx_modes[k]);
    end
    // floating pad shows which pull is on
    for (k = 0; k < 2; k++) begin
      apb(1'b1, DEG_OFS_CTRL, (k == 1) ? 32'hC00 : 32'h800);
      cyc(6);
      chk({pad_pulldown, bypass_input}, (k == 1) ? 2'b01 : 2'b10);
    end
    close_out();
  end
endmodule
`default_nettype wire
